// ==== hdl/abx_pkg.sv ====
// Purpose: Shared constants and types for the arithmetic, logic and branch executor.
// Assumes: 8-bit data path, 16-bit program counter, APB register window.
// Notes: Flag bit positions follow the usual I T H S V N Z C order.
package abx_pkg;

  typedef enum logic [5:0] {
    op_add = 6'b000000,
    op_add_carry = 6'b000001,
    op_word_plus_immediate = 6'b000010,
    op_sub = 6'b000011,
    op_difference_immediate = 6'b000100,
    op_difference_with_borrow = 6'b000101,
    op_borrow_difference_immediate = 6'b000110,
    op_word_minus_immediate = 6'b000111,
    op_and = 6'b001000,
    op_and_imm = 6'b001001,
    op_or = 6'b001010,
    op_or_imm = 6'b001011,
    op_xor = 6'b001100,
    op_ones_complement = 6'b001101,
    op_twos_complement = 6'b001110,
    op_mask_set_bits = 6'b001111,
    op_mask_clear_bits = 6'b010000,
    op_increment = 6'b010001,
    op_decrement = 6'b010010,
    op_zero_sign_test = 6'b010011,
    op_register_zeroing = 6'b010100,
    op_register_all_ones = 6'b010101,
    op_indirect_jump = 6'b010110,
    op_equal_compare_skip = 6'b010111,
    op_magnitude_compare = 6'b011000,
    op_compare_with_borrow = 6'b011001,
    op_compare_immediate = 6'b011010,
    op_skip_reg_bit_clear = 6'b011011,
    op_skip_reg_bit_set = 6'b011100,
    op_skip_io_bit_clear = 6'b011101,
    op_skip_io_bit_set = 6'b011110,
    op_branch_flag_set = 6'b011111,
    op_branch_flag_clear = 6'b100000,
    op_branch_equal = 6'b100001,
    op_branch_unequal = 6'b100010
  } abx_op_e;

  typedef enum logic [0:0] {
    abx_st_idle = 1'b0,
    abx_st_busy = 1'b1
  } abx_state_e;

  // Flag bit positions
  localparam int ABX_FB_C = 0;
  localparam int ABX_FB_Z = 1;
  localparam int ABX_FB_N = 2;
  localparam int ABX_FB_V = 3;
  localparam int ABX_FB_S = 4;
  localparam int ABX_FB_H = 5;

  // Flags touched by each instruction group
  localparam logic [7:0] ABX_MASK_ARITH = 8'h2F;
  localparam logic [7:0] ABX_MASK_WORD = 8'h1F;
  localparam logic [7:0] ABX_MASK_ZCNV = 8'h0F;
  localparam logic [7:0] ABX_MASK_ZNV = 8'h0E;

  // APB byte offsets
  localparam logic [7:0] ABX_OFF_FLAGS = 8'h00;
  localparam logic [7:0] ABX_OFF_PC = 8'h04;
  localparam logic [7:0] ABX_OFF_STATUS = 8'h08;

  // Reset values
  localparam logic [7:0] ABX_FLAGS_RST = 8'h00;
  localparam logic [15:0] ABX_PC_RST = 16'h0000;

  // Cycle counts and program counter steps
  localparam logic [1:0] ABX_CYC_ONE = 2'h1;
  localparam logic [1:0] ABX_CYC_TWO = 2'h2;
  localparam logic [1:0] ABX_CYC_THREE = 2'h3;
  localparam logic [15:0] ABX_STEP_NEXT = 16'h0001;
  localparam logic [15:0] ABX_STEP_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] ABX_STEP_SKIP_LONG = 16'h0003;

  localparam logic [7:0] ABX_ALL_ONES = 8'hFF;
  localparam logic [7:0] ABX_ALL_ZERO = 8'h00;
  localparam logic [7:0] ABX_ONE = 8'h01;

endpackage : abx_pkg

// ==== hdl/abx_addsub.sv ====
// Purpose: 8-bit adder and subtractor with carry, half-carry and overflow.
// Assumes: Subtraction takes cin as an extra borrow.
// Notes: Purely combinational.
`timescale 1ns/1ps
module abx_addsub (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic sub,
  output logic [7:0] y,
  output logic c,
  output logic h,
  output logic v
);
  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end
    y = full[7:0];
    c = full[8];
    h = low[4];
    // Signed overflow: operand signs decide when the result sign is wrong
    v = sub ? ((a[7] ^ b[7]) & (full[7] ^ a[7])) : (~(a[7] ^ b[7]) & (full[7] ^ a[7]));
  end
endmodule : abx_addsub

// ==== hdl/abx_exec.sv ====
// Purpose: Executes arithmetic, logic, compare, skip and branch instructions.
// Assumes: Decoder presents one decoded instruction with operands per accept.
// Notes: Results commit at the accept edge; ready stays low for the extra cycles.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module abx_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic exec_valid,
  output logic exec_ready,
  input wire abx_pkg::abx_op_e exec_op,
  input wire logic [7:0] exec_rd,
  input wire logic [7:0] exec_rd_hi,
  input wire logic [7:0] exec_rr,
  input wire logic [7:0] exec_imm,
  input wire logic [2:0] exec_bit,
  input wire logic [7:0] exec_io,
  input wire logic [2:0] exec_flag_sel,
  input wire logic [6:0] exec_offset,
  input wire logic [15:0] exec_z,
  input wire logic exec_next_long,
  output logic res_valid,
  output logic res_write,
  output logic res_word,
  output logic [7:0] res_lo,
  output logic [7:0] res_hi,
  output logic [7:0] flag_register,
  output logic [15:0] pc
);
  import abx_pkg::*;

  logic [7:0] flag_r;
  logic [15:0] pc_r;
  abx_state_e state_r;
  logic [1:0] stall_r;
  logic [1:0] last_cyc_r;
  logic res_valid_r;
  logic res_write_r;
  logic res_word_r;
  logic [7:0] res_lo_r;
  logic [7:0] res_hi_r;
  logic [31:0] prdata_r;
  logic err_r;

  logic accept;
  logic [7:0] src;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic alu_sub;
  logic [7:0] alu_y;
  logic alu_c;
  logic alu_h;
  logic alu_v;
  logic [16:0] wsum;
  logic [16:0] wdif;
  logic [15:0] word_in;
  logic [7:0] y;
  logic [7:0] yh;
  logic logic_upd;
  logic wr;
  logic word;
  logic cond;
  logic skip_op;
  logic [7:0] flags_nxt;
  logic [15:0] pc_nxt;
  logic [1:0] cyc;
  logic apb_wr;
  logic apb_setup;

  // Replace only the flags selected by mask
  function automatic logic [7:0] abx_upd(input logic [7:0] cur, input logic [7:0] mask,
                                         input logic [7:0] val);
    abx_upd = (cur & ~mask) | (val & mask);
  endfunction : abx_upd

  // Pack individual flag values into their positions
  function automatic logic [7:0] abx_pack(input logic z, input logic c, input logic n,
                                          input logic v, input logic s, input logic h);
    abx_pack = 8'h00;
    abx_pack[ABX_FB_Z] = z;
    abx_pack[ABX_FB_C] = c;
    abx_pack[ABX_FB_N] = n;
    abx_pack[ABX_FB_V] = v;
    abx_pack[ABX_FB_S] = s;
    abx_pack[ABX_FB_H] = h;
  endfunction : abx_pack

  assign accept = exec_valid & exec_ready;
  assign exec_ready = (state_r == abx_st_idle);
  assign apb_wr = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;
  assign word_in = {exec_rd_hi, exec_rd};
  assign wsum = {1'b0, word_in} + {9'h000, exec_imm};
  assign wdif = {1'b0, word_in} - {9'h000, exec_imm};

  // Constant forms take the immediate as second operand
  always_comb begin
    case (exec_op)
      op_difference_immediate, op_borrow_difference_immediate, op_and_imm, op_or_imm,
      op_mask_set_bits, op_mask_clear_bits, op_compare_immediate: begin
        src = exec_imm;
      end
      default: begin
        src = exec_rr;
      end
    endcase
  end

  always_comb begin
    alu_a = exec_rd;
    alu_b = src;
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    case (exec_op)
      op_add_carry: begin
        alu_cin = flag_r[ABX_FB_C];
      end
      op_sub, op_difference_immediate, op_magnitude_compare, op_compare_immediate: begin
        alu_sub = 1'b1;
      end
      op_difference_with_borrow, op_borrow_difference_immediate,
      op_compare_with_borrow: begin
        alu_sub = 1'b1;
        alu_cin = flag_r[ABX_FB_C];
      end
      op_twos_complement: begin
        alu_a = ABX_ALL_ZERO;
        alu_b = exec_rd;
        alu_sub = 1'b1;
      end
      op_increment: begin
        alu_b = ABX_ONE;
      end
      op_decrement: begin
        alu_b = ABX_ONE;
        alu_sub = 1'b1;
      end
      default: begin
      end
    endcase
  end

  abx_addsub u_addsub (
    .a(alu_a),
    .b(alu_b),
    .cin(alu_cin),
    .sub(alu_sub),
    .y(alu_y),
    .c(alu_c),
    .h(alu_h),
    .v(alu_v)
  );

  // Result, flag, program counter and cycle count for the presented instruction
  always_comb begin
    y = ABX_ALL_ZERO;
    yh = ABX_ALL_ZERO;
    logic_upd = 1'b0;
    wr = 1'b0;
    word = 1'b0;
    cond = 1'b0;
    skip_op = 1'b0;
    flags_nxt = flag_r;
    pc_nxt = pc_r + ABX_STEP_NEXT;
    cyc = ABX_CYC_ONE;
    case (exec_op)
      op_add, op_add_carry, op_sub, op_difference_immediate, op_difference_with_borrow,
      op_borrow_difference_immediate, op_twos_complement: begin
        y = alu_y;
        wr = 1'b1;
        flags_nxt = abx_upd(flag_r, ABX_MASK_ARITH,
                            abx_pack(alu_y == ABX_ALL_ZERO, alu_c, alu_y[7], alu_v,
                                     1'b0, alu_h));
      end
      op_magnitude_compare, op_compare_with_borrow, op_compare_immediate: begin
        // Difference only feeds the flags, the destination is untouched
        flags_nxt = abx_upd(flag_r, ABX_MASK_ARITH,
                            abx_pack(alu_y == ABX_ALL_ZERO, alu_c, alu_y[7], alu_v,
                                     1'b0, alu_h));
      end
      op_increment, op_decrement: begin
        y = alu_y;
        wr = 1'b1;
        flags_nxt = abx_upd(flag_r, ABX_MASK_ZNV,
                            abx_pack(alu_y == ABX_ALL_ZERO, 1'b0, alu_y[7], alu_v,
                                     1'b0, 1'b0));
      end
      op_and, op_and_imm: begin
        y = exec_rd & src;
        logic_upd = 1'b1;
      end
      op_or, op_or_imm, op_mask_set_bits: begin
        y = exec_rd | src;
        logic_upd = 1'b1;
      end
      op_xor: begin
        y = exec_rd ^ exec_rr;
        logic_upd = 1'b1;
      end
      op_mask_clear_bits: begin
        y = exec_rd & (ABX_ALL_ONES - src);
        logic_upd = 1'b1;
      end
      op_zero_sign_test: begin
        y = exec_rd & exec_rd;
        logic_upd = 1'b1;
      end
      op_register_zeroing: begin
        y = exec_rd ^ exec_rd;
        logic_upd = 1'b1;
      end
      op_ones_complement: begin
        y = ABX_ALL_ONES - exec_rd;
        wr = 1'b1;
        flags_nxt = abx_upd(flag_r, ABX_MASK_ZCNV,
                            abx_pack(y == ABX_ALL_ZERO, 1'b1, y[7], 1'b0,
                                     1'b0, 1'b0));
      end
      op_register_all_ones: begin
        y = ABX_ALL_ONES;
        wr = 1'b1;
      end
      op_word_plus_immediate: begin
        {yh, y} = wsum[15:0];
        wr = 1'b1;
        word = 1'b1;
        cyc = ABX_CYC_TWO;
        flags_nxt = abx_upd(flag_r, ABX_MASK_WORD,
                            abx_pack(wsum[15:0] == 16'h0000,
                                     ~wsum[15] & exec_rd_hi[7], wsum[15],
                                     ~exec_rd_hi[7] & wsum[15],
                                     wsum[15] ^ (~exec_rd_hi[7] & wsum[15]),
                                     1'b0));
      end
      op_word_minus_immediate: begin
        {yh, y} = wdif[15:0];
        wr = 1'b1;
        word = 1'b1;
        cyc = ABX_CYC_TWO;
        flags_nxt = abx_upd(flag_r, ABX_MASK_WORD,
                            abx_pack(wdif[15:0] == 16'h0000,
                                     wdif[15] & ~exec_rd_hi[7], wdif[15],
                                     exec_rd_hi[7] & ~wdif[15],
                                     wdif[15] ^ (exec_rd_hi[7] & ~wdif[15]),
                                     1'b0));
      end
      op_indirect_jump: begin
        pc_nxt = exec_z;
        cyc = ABX_CYC_TWO;
      end
      op_equal_compare_skip: begin
        skip_op = 1'b1;
        cond = (exec_rd == exec_rr);
      end
      op_skip_reg_bit_clear: begin
        skip_op = 1'b1;
        cond = ~exec_rr[exec_bit];
      end
      op_skip_reg_bit_set: begin
        skip_op = 1'b1;
        cond = exec_rr[exec_bit];
      end
      op_skip_io_bit_clear: begin
        skip_op = 1'b1;
        cond = ~exec_io[exec_bit];
      end
      op_skip_io_bit_set: begin
        skip_op = 1'b1;
        cond = exec_io[exec_bit];
      end
      op_branch_flag_set: begin
        cond = flag_r[exec_flag_sel];
      end
      op_branch_flag_clear: begin
        cond = ~flag_r[exec_flag_sel];
      end
      op_branch_equal: begin
        cond = flag_r[ABX_FB_Z];
      end
      op_branch_unequal: begin
        cond = ~flag_r[ABX_FB_Z];
      end
      default: begin
      end
    endcase
    if (logic_upd) begin
      // Logic results always clear overflow
      wr = 1'b1;
      flags_nxt = abx_upd(flag_r, ABX_MASK_ZNV,
                          abx_pack(y == ABX_ALL_ZERO, 1'b0, y[7], 1'b0,
                                   1'b0, 1'b0));
    end
    if (skip_op && cond) begin
      // Skipping a two-word instruction costs one more cycle
      pc_nxt = pc_r + (exec_next_long ? ABX_STEP_SKIP_LONG : ABX_STEP_SKIP_SHORT);
      cyc = exec_next_long ? ABX_CYC_THREE : ABX_CYC_TWO;
    end else if (!skip_op && cond) begin
      pc_nxt = pc_r + ABX_STEP_NEXT + {{9{exec_offset[6]}}, exec_offset};
      cyc = ABX_CYC_TWO;
    end
  end

  // Instruction commit wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= ABX_FLAGS_RST;
    end else if (accept) begin
      flag_r <= flags_nxt;
    end else if (apb_wr && paddr == ABX_OFF_FLAGS) begin
      flag_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= ABX_PC_RST;
    end else if (accept) begin
      pc_r <= pc_nxt;
    end else if (apb_wr && paddr == ABX_OFF_PC) begin
      pc_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid_r <= 1'b0;
      res_write_r <= 1'b0;
      res_word_r <= 1'b0;
      res_lo_r <= ABX_ALL_ZERO;
      res_hi_r <= ABX_ALL_ZERO;
    end else begin
      res_valid_r <= accept;
      if (accept) begin
        res_write_r <= wr;
        res_word_r <= word;
        res_lo_r <= y;
        res_hi_r <= yh;
      end
    end
  end

  // Multi-cycle instructions hold off the next accept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= abx_st_idle;
      stall_r <= 2'h0;
      last_cyc_r <= 2'h0;
    end else begin
      case (state_r)
        abx_st_idle: begin
          if (accept) begin
            last_cyc_r <= cyc;
            stall_r <= cyc - ABX_CYC_ONE;
            if (cyc != ABX_CYC_ONE) begin
              state_r <= abx_st_busy;
            end
          end
        end
        abx_st_busy: begin
          stall_r <= stall_r - 2'h1;
          if (stall_r == 2'h1) begin
            state_r <= abx_st_idle;
          end
        end
        default: begin
          state_r <= abx_st_idle;
        end
      endcase
    end
  end

  // Read data captured in the setup phase so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else if (apb_setup) begin
      err_r <= 1'b0;
      if (paddr == ABX_OFF_FLAGS) begin
        prdata_r <= {24'h000000, flag_r};
      end else if (paddr == ABX_OFF_PC) begin
        prdata_r <= {16'h0000, pc_r};
      end else if (paddr == ABX_OFF_STATUS) begin
        prdata_r <= {29'h00000000, last_cyc_r, state_r == abx_st_busy};
      end else begin
        prdata_r <= 32'h00000000;
        err_r <= 1'b1;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = err_r & psel & penable;
  assign res_valid = res_valid_r;
  assign res_write = res_write_r;
  assign res_word = res_word_r;
  assign res_lo = res_lo_r;
  assign res_hi = res_hi_r;
  assign flag_register = flag_r;
  assign pc = pc_r;

endmodule : abx_exec

// ==== verif/abx_exec_assertions.sv ====
// Purpose: Port-level checker for the arithmetic, logic and branch executor.
// Assumes: Results and flags land at the accept edge, seen one cycle later.
// Notes: Only relations between top-level ports; bound at the foot.
`timescale 1ns/1ps
module abx_exec_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic exec_valid,
  input wire logic exec_ready,
  input wire abx_pkg::abx_op_e exec_op,
  input wire logic [7:0] exec_rd,
  input wire logic [7:0] exec_rd_hi,
  input wire logic [7:0] exec_rr,
  input wire logic [7:0] exec_imm,
  input wire logic [6:0] exec_offset,
  input wire logic [15:0] exec_z,
  input wire logic exec_next_long,
  input wire logic res_valid,
  input wire logic res_write,
  input wire logic [7:0] res_lo,
  input wire logic [7:0] res_hi,
  input wire logic [7:0] flag_register,
  input wire logic [15:0] pc
);
  import abx_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = exec_valid && exec_ready;

  property p_add;
    acc && exec_op == op_add |=> res_write && res_lo == 8'($past(exec_rd) + $past(exec_rr));
  endproperty
  a_add: assert property (p_add) else $error("add result wrong"); // Sum

  property p_sub;
    acc && exec_op == op_sub |=> res_lo == 8'($past(exec_rd) - $past(exec_rr))
      && flag_register[0] == ($past(exec_rd) < $past(exec_rr));
  endproperty
  a_sub: assert property (p_sub) else $error("sub result or borrow wrong"); // Diff

  property p_word;
    acc && (exec_op == op_word_plus_immediate || exec_op == op_word_minus_immediate)
      |=> res_valid && !exec_ready ##1 exec_ready;
  endproperty
  a_word: assert property (p_word) else $error("word op timing wrong"); // Two

  property p_wsum;
    acc && exec_op == op_word_plus_immediate |=> {res_hi, res_lo} - {8'h00, $past(exec_imm)}
      == {$past(exec_rd_hi), $past(exec_rd)} && flag_register[4] == (flag_register[2] ^ flag_register[3]);
  endproperty
  a_wsum: assert property (p_wsum) else $error("word sum or sign wrong"); // Pair

  property p_logic;
    acc && exec_op inside {op_and, op_and_imm, op_or, op_or_imm, op_xor} |=> !flag_register[3]
      && flag_register[1] == (res_lo == 8'h00) && flag_register[0] == $past(flag_register[0])
      && flag_register[5] == $past(flag_register[5]);
  endproperty
  a_logic: assert property (p_logic) else $error("logic flags wrong"); // Flags

  property p_indirect_jump;
    acc && exec_op == op_indirect_jump |=> pc == $past(exec_z) && !exec_ready ##1 exec_ready;
  endproperty
  a_indirect_jump: assert property (p_indirect_jump) else $error("indirect jump wrong"); // Jump

  property p_equal_compare_skip;
    acc && exec_op == op_equal_compare_skip |=> $stable(flag_register) && pc == $past(pc)
      + (($past(exec_rd) != $past(exec_rr)) ? 16'h0001 : $past(exec_next_long) ? 16'h0003 : 16'h0002);
  endproperty
  a_equal_compare_skip: assert property (p_equal_compare_skip) else $error("equal skip wrong"); // Skip

  property p_cmp;
    acc && exec_op inside {op_magnitude_compare, op_compare_with_borrow, op_compare_immediate}
      |=> res_valid && !res_write && exec_ready;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare stored a result"); // Cmp

  property p_beq;
    acc && exec_op == op_branch_equal |=> $stable(flag_register) && pc == $past(pc) + 16'h0001
      + ($past(flag_register[1]) ? {{9{$past(exec_offset[6])}}, $past(exec_offset)} : 16'h0000);
  endproperty
  a_beq: assert property (p_beq) else $error("equal branch wrong"); // Branch

  property p_ser;
    acc && exec_op == op_register_all_ones |=> res_write && res_lo == 8'hFF
      && $stable(flag_register) && exec_ready;
  endproperty
  a_ser: assert property (p_ser) else $error("all ones wrong"); // Ones
endmodule : abx_exec_checker

bind abx_exec abx_exec_checker u_chk (.pclk, .presetn, .exec_valid, .exec_ready, .exec_op,
  .exec_rd, .exec_rd_hi, .exec_rr, .exec_imm, .exec_offset, .exec_z, .exec_next_long,
  .res_valid, .res_write, .res_lo, .res_hi, .flag_register, .pc);

// ==== verif/abx_exec_bench.sv ====
// Purpose: Table-driven self-checking bench for the executor.
// Assumes: Flags and pc preset over APB before each table vector; pc only, once, before the back-to-back run.
// Notes: Byte ops keep S, word ops keep H, as the designer chose.
`timescale 1ns/1ps
module abx_exec_bench;
  import abx_pkg::*;
  typedef struct {
    abx_op_e op;
    logic [7:0] a, b, k, pre;
    logic [15:0] res;
    logic [7:0] fl;
    logic [15:0] epc;
    logic [1:0] cyc;
  } abx_vec_s;
  // Operand a: rd and io; b: hi, rr, flag select; k: imm, bit, offset, long
  abx_vec_s tv [39] = '{
    '{op_add, 8'h3A, 8'h28, 8'h00, 8'hD0, 16'h0062, 8'hF0, 16'h0101, 2'h1},
    '{op_add, 8'h80, 8'h80, 8'h00, 8'h00, 16'h0000, 8'h0B, 16'h0101, 2'h1},
    '{op_add_carry, 8'hFF, 8'h00, 8'h00, 8'h01, 16'h0000, 8'h23, 16'h0101, 2'h1},
    '{op_sub, 8'h10, 8'h01, 8'h00, 8'h00, 16'h000F, 8'h20, 16'h0101, 2'h1},
    '{op_difference_immediate, 8'h00, 8'h00, 8'h01, 8'h00, 16'h00FF, 8'h25, 16'h0101, 2'h1},
    '{op_difference_with_borrow, 8'h05, 8'h04, 8'h00, 8'h01, 16'h0000, 8'h02, 16'h0101, 2'h1},
    '{op_borrow_difference_immediate, 8'h80, 8'h00, 8'h00, 8'h01, 16'h007F, 8'h28, 16'h0101, 2'h1},
    '{op_and, 8'hF0, 8'h8F, 8'h00, 8'h3B, 16'h0080, 8'h35, 16'h0101, 2'h1},
    '{op_and_imm, 8'h0F, 8'h00, 8'hF0, 8'h00, 16'h0000, 8'h02, 16'h0101, 2'h1},
    '{op_or, 8'h40, 8'h01, 8'h00, 8'h08, 16'h0041, 8'h00, 16'h0101, 2'h1},
    '{op_or_imm, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0080, 8'h04, 16'h0101, 2'h1},
    '{op_xor, 8'hAA, 8'hAA, 8'h00, 8'h00, 16'h0000, 8'h02, 16'h0101, 2'h1},
    '{op_ones_complement, 8'h55, 8'h00, 8'h00, 8'h00, 16'h00AA, 8'h05, 16'h0101, 2'h1},
    '{op_twos_complement, 8'h01, 8'h00, 8'h00, 8'h00, 16'h00FF, 8'h25, 16'h0101, 2'h1},
    '{op_mask_set_bits, 8'h01, 8'h00, 8'h80, 8'h00, 16'h0081, 8'h04, 16'h0101, 2'h1},
    '{op_mask_clear_bits, 8'hFF, 8'h00, 8'h0F, 8'h00, 16'h00F0, 8'h04, 16'h0101, 2'h1},
    '{op_increment, 8'h7F, 8'h00, 8'h00, 8'h01, 16'h0080, 8'h0D, 16'h0101, 2'h1},
    '{op_decrement, 8'h01, 8'h00, 8'h00, 8'h20, 16'h0000, 8'h22, 16'h0101, 2'h1},
    '{op_zero_sign_test, 8'h80, 8'h00, 8'h00, 8'h00, 16'h0080, 8'h04, 16'h0101, 2'h1},
    '{op_register_zeroing, 8'h5A, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h02, 16'h0101, 2'h1},
    '{op_register_all_ones, 8'h00, 8'h00, 8'h00, 8'h2F, 16'h00FF, 8'h2F, 16'h0101, 2'h1},
    '{op_magnitude_compare, 8'h10, 8'h20, 8'h00, 8'h00, 16'h0000, 8'h05, 16'h0101, 2'h1},
    '{op_compare_with_borrow, 8'h20, 8'h1F, 8'h00, 8'h01, 16'h0000, 8'h22, 16'h0101, 2'h1},
    '{op_compare_immediate, 8'h7F, 8'h00, 8'hFF, 8'h00, 16'h0000, 8'h0D, 16'h0101, 2'h1},
    '{op_word_plus_immediate, 8'hFF, 8'h7F, 8'h01, 8'h20, 16'h8000, 8'h2C, 16'h0101, 2'h2},
    '{op_word_minus_immediate, 8'h00, 8'h00, 8'h01, 8'h00, 16'hFFFF, 8'h15, 16'h0101, 2'h2},
    '{op_indirect_jump, 8'h34, 8'h12, 8'h00, 8'h00, 16'h0000, 8'h00, 16'h1234, 2'h2},
    '{op_equal_compare_skip, 8'h12, 8'h12, 8'h00, 8'h00, 16'h0000, 8'h00, 16'h0102, 2'h2},
    '{op_equal_compare_skip, 8'h12, 8'h12, 8'h80, 8'h00, 16'h0000, 8'h00, 16'h0103, 2'h3},
    '{op_equal_compare_skip, 8'h12, 8'h13, 8'h00, 8'h00, 16'h0000, 8'h00, 16'h0101, 2'h1},
    '{op_skip_reg_bit_clear, 8'h00, 8'hFE, 8'h00, 8'h00, 16'h0000, 8'h00, 16'h0102, 2'h2},
    '{op_skip_reg_bit_set, 8'h00, 8'h80, 8'h87, 8'h00, 16'h0000, 8'h00, 16'h0103, 2'h3},
    '{op_skip_io_bit_clear, 8'h08, 8'h00, 8'h03, 8'h00, 16'h0000, 8'h00, 16'h0101, 2'h1},
    '{op_skip_io_bit_set, 8'h08, 8'h00, 8'h03, 8'h00, 16'h0000, 8'h00, 16'h0102, 2'h2},
    '{op_branch_flag_set, 8'h00, 8'h02, 8'h7F, 8'h04, 16'h0000, 8'h04, 16'h0100, 2'h2},
    '{op_branch_flag_clear, 8'h00, 8'h05, 8'h00, 8'h20, 16'h0000, 8'h20, 16'h0101, 2'h1},
    '{op_branch_flag_clear, 8'h00, 8'h06, 8'h3F, 8'h00, 16'h0000, 8'h00, 16'h0140, 2'h2},
    '{op_branch_equal, 8'h00, 8'h00, 8'h40, 8'h02, 16'h0000, 8'h02, 16'h00C1, 2'h2},
    '{op_branch_unequal, 8'h00, 8'h00, 8'h40, 8'h02, 16'h0000, 8'h02, 16'h0101, 2'h1}
  };
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic exec_valid = 1'b0;
  logic exec_ready;
  abx_op_e exec_op = op_add;
  logic [7:0] a_q = 8'h00;
  logic [7:0] b_q = 8'h00;
  logic [7:0] k_q = 8'h00;
  logic res_valid;
  logic res_write;
  logic res_word;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic [7:0] flag_register;
  logic [15:0] pc;
  int failures = 0;
  int compares = 0;
  logic [31:0] rd_v;
  logic err_v;
  logic rv_v;
  logic [31:0] cyc_v;
  logic wr_e;

  always #4 pclk = ~pclk;

  abx_exec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .exec_valid, .exec_ready, .exec_op, .exec_rd(a_q), .exec_rd_hi(b_q),
    .exec_rr(b_q), .exec_imm(k_q), .exec_bit(k_q[2:0]), .exec_io(a_q),
    .exec_flag_sel(b_q[2:0]), .exec_offset(k_q[6:0]), .exec_z({b_q, a_q}),
    .exec_next_long(k_q[7]), .res_valid, .res_write, .res_word, .res_lo, .res_hi,
    .flag_register, .pc);

  task automatic conclude;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Zero-wait slave, but the wait stays bounded in case pready drops
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ex(input abx_op_e o, input logic [7:0] a, input logic [7:0] b,
                    input logic [7:0] k);
    int n;
    n = 0;
    @(posedge pclk);
    exec_op <= o;
    a_q <= a;
    b_q <= b;
    k_q <= k;
    exec_valid <= 1'b1;
    @(negedge pclk);
    while (exec_ready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (exec_ready !== 1'b1) begin
      failures++;
      conclude();
    end
    @(posedge pclk);
    exec_valid <= 1'b0;
    @(negedge pclk);
    rv_v = res_valid;
    cyc_v = 1;
    while (exec_ready !== 1'b1 && cyc_v < 8) begin
      @(negedge pclk);
      cyc_v++;
    end
    if (exec_ready !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask : ex

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ABX_OFF_FLAGS, 32'h0);
    chk(rd_v, 32'h0000_0000); // Flags clear after reset
    apb(1'b0, ABX_OFF_PC, 32'h0);
    chk(rd_v, 32'h0000_0000); // Pc starts at zero
    apb(1'b0, 8'h0C, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h0000_0001); // Unmapped read refused
    foreach (tv[i]) begin
      apb(1'b1, ABX_OFF_FLAGS, {24'h0, tv[i].pre});
      apb(1'b1, ABX_OFF_PC, 32'h0000_0100);
      ex(tv[i].op, tv[i].a, tv[i].b, tv[i].k);
      wr_e = (tv[i].op < op_indirect_jump);
      chk(flag_register, tv[i].fl); // Flags
      chk(pc, tv[i].epc); // Pc
      chk(cyc_v, tv[i].cyc); // Cycles
      chk({res_write, rv_v}, {wr_e, 1'b1}); // Store or not
      if (tv[i].op == op_word_plus_immediate || tv[i].op == op_word_minus_immediate)
        chk({res_word, res_hi, res_lo}, {1'b1, tv[i].res}); // Pair
      else if (wr_e)
        chk({res_word, res_lo}, {1'b0, tv[i].res[7:0]}); // Byte
    end
    // Back to back: three increments, then a word op held through its busy cycle
    apb(1'b1, ABX_OFF_PC, 32'h0000_0200);
    @(posedge pclk);
    exec_op <= op_increment;
    a_q <= 8'h01;
    exec_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    exec_op <= op_word_plus_immediate;
    k_q <= 8'h02;
    repeat (3) @(posedge pclk);
    exec_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(pc, 32'h0000_0205); // Busy cycle refuses, then retakes
    apb(1'b0, ABX_OFF_STATUS, 32'h0);
    chk(rd_v, 32'h0000_0004); // Last count two, idle
    conclude();
  end
endmodule : abx_exec_bench
